/* File: src/sbt_regs.svh */
// Constants of the sixteen-bit timer: offsets, fields, resets, counts.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef SBT_REGS_SVH
`define SBT_REGS_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define SBT_IDX_COUNT 16'h0100
`define SBT_IDX_PERIOD 16'h0102
`define SBT_IDX_CONTROL 16'h0104
`define SBT_IDX_IRQ 16'h0106
`define SBT_IDX_OSC 16'h0108
`define SBT_ADDR_COUNT 12'h400
`define SBT_ADDR_PERIOD 12'h408
`define SBT_ADDR_CONTROL 12'h410
`define SBT_ADDR_IRQ 12'h418
`define SBT_ADDR_OSC 12'h420

// ****************************************************************
// Control register fields
// ****************************************************************
`define SBT_CTL_ON 15
`define SBT_CTL_IDLE_STOP 13
`define SBT_CTL_GATE 6
`define SBT_CTL_PS_HI 5
`define SBT_CTL_PS_LO 4
`define SBT_CTL_SYNC 2
`define SBT_CTL_CLKSEL 1

// ****************************************************************
// Own registers: interrupt flag/enable and oscillator control
// ****************************************************************
`define SBT_IRQ_FLAG 0
`define SBT_IRQ_ENABLE 1
`define SBT_OSC_LP_EN 1

// ****************************************************************
// Reset values
// ****************************************************************
`define SBT_RST_COUNT 16'h0000
`define SBT_RST_PERIOD 16'hFFFF
`define SBT_RST_CONTROL 16'h0000

// ****************************************************************
// Prescale terminal counts (ratio minus one)
// ****************************************************************
`define SBT_PS_TC_1 8'h00
`define SBT_PS_TC_8 8'h07
`define SBT_PS_TC_64 8'h3F
`define SBT_PS_TC_256 8'hFF

// ****************************************************************
// Bus answers
// ****************************************************************
`define SBT_RESP_OKAY 2'h0
`define SBT_RESP_SLVERR 2'h2

`endif

/* File: src/sbt_pkg.sv */
// Types shared by the sixteen-bit timer files.
// Assumes nothing beyond a SystemVerilog compiler.
package sbt_pkg;

  // ****************************************************************
  // Decoded control register
  // ****************************************************************
  typedef struct packed {
    logic timer_on;
    logic idle_stop;
    logic gate_accum_enable;
    logic [1:0] prescale_select;
    logic ext_sync_select;
    logic clock_source_select;
  } sbt_ctrl_type;

  // ****************************************************************
  // Processor power state
  // ****************************************************************
  typedef struct packed {
    logic idle;
    logic sleep;
  } sbt_power_type;

  // ****************************************************************
  // Bus channel state, one-hot
  // ****************************************************************
  typedef enum logic [1:0] {
    SBT_CH_IDLE = 2'b01,
    SBT_CH_RESP = 2'b10
  } sbt_ch_state_type;

endpackage : sbt_pkg

/* File: src/sbt_sync3.sv */
// Three-stage synchroniser for a pin that arrives from outside aclk.
// Assumes the pin may change at any time; output follows when the
// second and third stages agree.
`timescale 1ns/10ps
module sbt_sync3 (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Synchronous reset, low
  input wire logic pin, // Asynchronous pin level
  output logic level // Filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level = level_q;
endmodule : sbt_sync3

/* File: src/sbt_prescaler.sv */
// Input prescaler: passes one tick out of 1, 8, 64 or 256.
// Assumes tick_in is a one-cycle pulse on aclk.
`timescale 1ns/10ps
`include "sbt_regs.svh"
module sbt_prescaler #(
  parameter int WIDTH = 8 // Counter width
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Synchronous reset, low
  input wire logic tick_in, // Source tick
  input wire logic clear, // Clear counter
  input wire logic [1:0] select, // Ratio code
  output logic tick_out // Divided tick
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] tc;

  always_comb begin
    case (select)
      2'h0: tc = WIDTH'(`SBT_PS_TC_1);
      2'h1: tc = WIDTH'(`SBT_PS_TC_8);
      2'h2: tc = WIDTH'(`SBT_PS_TC_64);
      default: tc = WIDTH'(`SBT_PS_TC_256);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (tick_in) begin
      if (cnt_q >= tc) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + WIDTH'(1);
      end
    end
  end

  assign tick_out = tick_in && !clear && (cnt_q >= tc);
endmodule : sbt_prescaler

/* File: src/sbt_timer.sv */
// Sixteen-bit timer with period match, gated accumulation, prescaler,
// idle/sleep behaviour and a low-power oscillator clock mode.
// Assumes an AXI4-Lite master on aclk; pins and the oscillator output
// are asynchronous and are synchronised here.
`timescale 1ns/10ps
`include "sbt_regs.svh"

// Overview of operation
// - Gate mode counts cycles while pin high
// - Idle-stop halts counting during Idle only
// - Prescale input clock by 1, 8, 64, 256
// - Count or control write clears prescaler
// - No prescaler clear while timer off
// - Control write leaves count unchanged
// - Sleep counts only on, external, asynchronous
// - Period match sets flag; enable gates request
// - Gate falling edge also sets flag
// - Oscillator edges counted, wrap at period
// - Oscillator enable blocks timer, enables wake
// - Oscillator clock mode counts through Sleep when asynchronous
// - Control bit layout; other bits zero
// - Timer mode counts every cycle, wraps
// - Synchronous counter counts synchronised edges
// - Asynchronous counter counts edges, wraps
module sbt_timer #(
  parameter int ADDR_W = 12 // AXI address width
) (
  input wire logic aclk, // Instruction clock
  input wire logic aresetn, // Synchronous reset, low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic gate_clock_pin, // Gate or external clock pin
  input wire logic lp_osc_out, // Low-power oscillator output
  input wire logic cpu_idle, // Processor in Idle
  input wire logic cpu_sleep, // Processor in Sleep
  output logic period_irq_flag, // Sticky interrupt flag
  output logic irq_request, // Flag gated by enable
  output logic wake_event // Carry-out wake pulse
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [15:0] count_q;
  logic [15:0] period_q;
  sbt_pkg::sbt_ctrl_type ctrl_q;
  sbt_pkg::sbt_power_type power;
  logic flag_q;
  logic irq_en_q;
  logic lp_osc_en_q;
  logic wake_q;
  logic gate_prev_q;
  logic ext_prev_q;

  sbt_pkg::sbt_ch_state_type wr_state_q;
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic gate_level;
  logic osc_level;

  sbt_sync3 u_sync_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(gate_clock_pin),
    .level(gate_level)
  );

  sbt_sync3 u_sync_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(lp_osc_out),
    .level(osc_level)
  );

  assign power.idle = cpu_idle;
  assign power.sleep = cpu_sleep;

  // ****************************************************************
  // Write channel: address and data taken in either order
  // ****************************************************************
  logic wr_fire;
  logic [15:0] wr_mask;
  logic [15:0] wr_val;
  logic wr_any;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_irq;
  logic wr_osc;
  logic wr_hit;

  assign s_axi_awready = !aw_full_q && (wr_state_q == sbt_pkg::SBT_CH_IDLE);
  assign s_axi_wready = !w_full_q && (wr_state_q == sbt_pkg::SBT_CH_IDLE);
  assign s_axi_bvalid = (wr_state_q == sbt_pkg::SBT_CH_RESP);
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_full_q && w_full_q &&
                   (wr_state_q == sbt_pkg::SBT_CH_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= sbt_pkg::SBT_CH_IDLE;
      bresp_q <= `SBT_RESP_OKAY;
    end else begin
      case (wr_state_q)
        sbt_pkg::SBT_CH_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= sbt_pkg::SBT_CH_RESP;
            bresp_q <= wr_hit ? `SBT_RESP_OKAY : `SBT_RESP_SLVERR;
          end
        end
        sbt_pkg::SBT_CH_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= sbt_pkg::SBT_CH_IDLE;
          end
        end
        default: wr_state_q <= sbt_pkg::SBT_CH_IDLE;
      endcase
    end
  end

  // Address decode; low two bits ignored, strobes above lane 1 unused
  always_comb begin
    wr_count = 1'b0;
    wr_period = 1'b0;
    wr_control = 1'b0;
    wr_irq = 1'b0;
    wr_osc = 1'b0;
    if (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_COUNT >> 2) begin
      wr_count = wr_fire && wr_any;
    end else if (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_PERIOD >> 2) begin
      wr_period = wr_fire && wr_any;
    end else if (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_CONTROL >> 2) begin
      wr_control = wr_fire && wr_any;
    end else if (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_IRQ >> 2) begin
      wr_irq = wr_fire && wr_any;
    end else if (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_OSC >> 2) begin
      wr_osc = wr_fire && wr_any;
    end
  end

  assign wr_hit = (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_COUNT >> 2) ||
                  (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_PERIOD >> 2) ||
                  (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_CONTROL >> 2) ||
                  (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_IRQ >> 2) ||
                  (aw_addr_q[ADDR_W-1:2] == `SBT_ADDR_OSC >> 2);
  assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_any = |w_strb_q[1:0];

  // ****************************************************************
  // Control register and own registers
  // ****************************************************************
  logic [15:0] ctrl_word;
  logic [15:0] ctrl_new;

  // Only implemented bits are stored, so the rest read as zero
  assign ctrl_word = {ctrl_q.timer_on, 1'b0, ctrl_q.idle_stop, 6'h00,
                      ctrl_q.gate_accum_enable, ctrl_q.prescale_select,
                      1'b0, ctrl_q.ext_sync_select,
                      ctrl_q.clock_source_select, 1'b0};
  assign wr_val = w_data_q[15:0];
  assign ctrl_new = (ctrl_word & ~wr_mask) | (wr_val & wr_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sbt_pkg::sbt_ctrl_type'(7'h00);
    end else if (wr_control) begin
      ctrl_q.timer_on <= ctrl_new[`SBT_CTL_ON];
      ctrl_q.idle_stop <= ctrl_new[`SBT_CTL_IDLE_STOP];
      ctrl_q.gate_accum_enable <= ctrl_new[`SBT_CTL_GATE];
      ctrl_q.prescale_select <=
        ctrl_new[`SBT_CTL_PS_HI:`SBT_CTL_PS_LO];
      ctrl_q.ext_sync_select <= ctrl_new[`SBT_CTL_SYNC];
      ctrl_q.clock_source_select <= ctrl_new[`SBT_CTL_CLKSEL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= `SBT_RST_PERIOD;
    end else if (wr_period) begin
      period_q <= (period_q & ~wr_mask) | (wr_val & wr_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= 1'b0;
      lp_osc_en_q <= 1'b0;
    end else begin
      if (wr_irq && w_strb_q[0]) begin
        irq_en_q <= wr_val[`SBT_IRQ_ENABLE];
      end
      if (wr_osc && w_strb_q[0]) begin
        lp_osc_en_q <= wr_val[`SBT_OSC_LP_EN];
      end
    end
  end

  // ****************************************************************
  // Clock source selection and run conditions
  // ****************************************************************
  logic ext_level;
  logic ext_rise;
  logic gate_fall;
  logic gate_mode;
  logic run;
  logic src_tick;
  logic ps_clear;
  logic ps_tick;
  logic match;

  // Oscillator replaces the pin as external source when enabled
  assign ext_level = lp_osc_en_q ? osc_level : gate_level;
  assign ext_rise = ext_level && !ext_prev_q;
  assign gate_mode = ctrl_q.timer_on && ctrl_q.gate_accum_enable &&
                     !ctrl_q.clock_source_select;
  assign gate_fall = gate_mode && gate_prev_q && !gate_level;

  always_comb begin
    run = ctrl_q.timer_on;
    if (power.idle && ctrl_q.idle_stop) begin
      run = 1'b0;
    end
    // Instruction clock is stopped in Sleep; only async external runs
    if (power.sleep && !(ctrl_q.clock_source_select &&
        !ctrl_q.ext_sync_select)) begin
      run = 1'b0;
    end
    if (lp_osc_en_q && !ctrl_q.clock_source_select) begin
      run = 1'b0;
    end
  end

  // Both counter modes see the synchronised edge: no other clock here
  always_comb begin
    src_tick = 1'b0;
    if (run) begin
      if (ctrl_q.clock_source_select) begin
        src_tick = ext_rise;
      end else if (ctrl_q.gate_accum_enable) begin
        src_tick = gate_level;
      end else begin
        src_tick = 1'b1;
      end
    end
  end

  assign ps_clear = (wr_count || wr_control) && ctrl_q.timer_on;

  sbt_prescaler #(
    .WIDTH(8)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(src_tick),
    .clear(ps_clear),
    .select(ctrl_q.prescale_select),
    .tick_out(ps_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      gate_prev_q <= gate_level;
      ext_prev_q <= ext_level;
    end
  end

  // ****************************************************************
  // Counter, match flag and wake event
  // ****************************************************************
  assign match = ps_tick && (count_q == period_q);

  // Software write wins over a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `SBT_RST_COUNT;
    end else if (wr_count) begin
      count_q <= (count_q & ~wr_mask) | (wr_val & wr_mask);
    end else if (match) begin
      count_q <= 16'h0000;
    end else if (ps_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (match || gate_fall) begin
      flag_q <= 1'b1;
    end else if (wr_irq && w_strb_q[0] && wr_val[`SBT_IRQ_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= match && lp_osc_en_q;
    end
  end

  assign period_irq_flag = flag_q;
  assign irq_request = flag_q && irq_en_q;
  assign wake_event = wake_q;

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic [ADDR_W-3:0] rd_idx;

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SBT_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q <= `SBT_RESP_OKAY;
      if (rd_idx == `SBT_ADDR_COUNT >> 2) begin
        rdata_q <= {16'h0000, count_q};
      end else if (rd_idx == `SBT_ADDR_PERIOD >> 2) begin
        rdata_q <= {16'h0000, period_q};
      end else if (rd_idx == `SBT_ADDR_CONTROL >> 2) begin
        rdata_q <= {16'h0000, ctrl_word};
      end else if (rd_idx == `SBT_ADDR_IRQ >> 2) begin
        rdata_q <= {30'h0, irq_en_q, flag_q};
      end else if (rd_idx == `SBT_ADDR_OSC >> 2) begin
        rdata_q <= {30'h0, lp_osc_en_q, 1'b0};
      end else begin
        rdata_q <= 32'h00000000;
        rresp_q <= `SBT_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : sbt_timer

/* File: verif/sbt_timer_checker.sv */
// Port-level assertions for the sixteen-bit timer.
// Assumes one clock domain and a bind onto every sbt_timer.
`timescale 1ns/10ps
module sbt_timer_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awready, // Aw ready
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // Ar valid
  input wire logic s_axi_arready, // Ar ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic period_irq_flag, // Flag
  input wire logic irq_request, // Request
  input wire logic wake_event // Wake pulse
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready during response");
  chk_bvalid_release: assert property (
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped without bready");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high while rvalid");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rvalid_release: assert property (
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped without rready");
  chk_flag_sticky: assert property (
    $fell(period_irq_flag) |-> s_axi_bvalid)
    else $error("flag cleared without a write");
  chk_irq_gated: assert property (
    irq_request |-> period_irq_flag)
    else $error("request without flag");
  chk_wake_single: assert property (
    wake_event |=> !wake_event)
    else $error("wake pulse longer than one cycle");
endmodule : sbt_timer_checker

bind sbt_timer sbt_timer_checker sbt_timer_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .period_irq_flag(period_irq_flag),
  .irq_request(irq_request), .wake_event(wake_event));

/* File: verif/sbt_ext_source.sv */
// Far side: gate or external clock pin and the oscillator output.
// Assumes the bench calls its tasks; lines rest low between bursts.
`timescale 1ns/10ps
module sbt_ext_source (
  output logic gate_clock_pin, // Gate or clock
  output logic lp_osc_out // Oscillator out
);
  initial begin
    gate_clock_pin = 1'b0;
    lp_osc_out = 1'b0;
  end
  // Offset keeps edges away from aclk edges
  task automatic gate(input int ns);
    #37 gate_clock_pin = 1'b1;
    #(ns) gate_clock_pin = 1'b0;
  endtask : gate
  // Slow against aclk so every edge survives synchronising
  task automatic burst(input logic osc, input int n);
    repeat (n) begin
      #730 gate_clock_pin = !osc;
      lp_osc_out = osc;
      #730 gate_clock_pin = 1'b0;
      lp_osc_out = 1'b0;
    end
  endtask : burst
endmodule : sbt_ext_source

/* File: verif/test_sbt_timer.sv */
// Self-checking bench for the sixteen-bit timer over AXI4-Lite.
// Assumes the bound checker and the far-side source model.
`timescale 1ns/10ps
`include "sbt_regs.svh"
module test_sbt_timer;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cpu_idle = 1'b0, cpu_sleep = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, flag, irq, wake;
  logic pin, osc;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, q, v;
  int n_mismatch = 0, comparisons = 0, cyc = 0, n_wake = 0, t0;

  always #50 aclk = !aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  always @(posedge aclk) if (wake === 1'b1) n_wake <= n_wake + 1;

  sbt_timer sbt_timer_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gate_clock_pin(pin), .lp_osc_out(osc),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .period_irq_flag(flag),
    .irq_request(irq), .wake_event(wake));
  sbt_ext_source sbt_ext_source_inst (.gate_clock_pin(pin),
    .lp_osc_out(osc));

  // ****
  // Shared tasks
  // ****
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic give_up(input logic hit);
    if (hit) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : give_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (arready === 1'b1) arvalid <= 1'b0;
      if ((w ? bvalid : rvalid) === 1'b1) break;
    end
    q = rdata;
    r = w ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
    give_up(i == 40);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wflag;
    int i;
    for (i = 0; i < 4000 && flag !== 1'b1; i++) @(posedge aclk);
    give_up(i == 4000);
  endtask : wflag

  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd(`SBT_ADDR_COUNT);
    check(q, 32'h0);
    rd(`SBT_ADDR_PERIOD);
    check(q, 32'h0000FFFF);
    rd(`SBT_ADDR_CONTROL);
    check(q, 32'h0);
    wr(`SBT_ADDR_CONTROL, 32'hFFFFFFFF);
    rd(`SBT_ADDR_CONTROL);
    check(q, 32'h0000A076);
    wr(`SBT_ADDR_CONTROL, 32'h0);
    check({30'h0, r}, 32'h0);
    rd(12'h430);
    check({q[31:2], r}, 32'h2);
    wr(12'h430, 32'h0);
    check({30'h0, r}, 32'h2);
  endtask : t_regs
  task automatic t_prescale;
    int k;
    int ratio [4] = '{1, 8, 64, 256};
    wr(`SBT_ADDR_PERIOD, 32'h9);
    for (k = 0; k < 4; k++) begin
      wr(`SBT_ADDR_CONTROL, 32'h8000 | (32'(k) << 4));
      // Count write restarts the prescaler: ten ratios to the match
      wr(`SBT_ADDR_COUNT, 32'h0);
      t0 = cyc;
      wr(`SBT_ADDR_IRQ, 32'h1);
      wflag();
      check(cyc - t0, 10 * ratio[k]);
    end
    check({31'h0, irq}, 32'h0);
    wr(`SBT_ADDR_IRQ, 32'h2);
    check({31'h0, irq}, 32'h1);
  endtask : t_prescale
  task automatic t_gate;
    wr(`SBT_ADDR_CONTROL, 32'h8040);
    wr(`SBT_ADDR_PERIOD, 32'hFFFF);
    wr(`SBT_ADDR_COUNT, 32'h0);
    wr(`SBT_ADDR_IRQ, 32'h1);
    check({31'h0, flag}, 32'h0);
    sbt_ext_source_inst.gate(2000);
    repeat (8) @(posedge aclk);
    rd(`SBT_ADDR_COUNT);
    check(q, 32'd20);
    check({31'h0, flag}, 32'h1);
  endtask : t_gate
  task automatic t_idle;
    cpu_idle <= 1'b1;
    wr(`SBT_ADDR_CONTROL, 32'hA000);
    rd(`SBT_ADDR_COUNT);
    v = q;
    rd(`SBT_ADDR_COUNT);
    check(q, v);
    wr(`SBT_ADDR_CONTROL, 32'h8000);
    rd(`SBT_ADDR_COUNT);
    v = q;
    rd(`SBT_ADDR_COUNT);
    check({31'h0, q == v}, 32'h0);
    cpu_idle <= 1'b0;
  endtask : t_idle
  task automatic t_sleep;
    cpu_sleep <= 1'b1;
    rd(`SBT_ADDR_COUNT);
    v = q;
    rd(`SBT_ADDR_COUNT);
    check(q, v);
    wr(`SBT_ADDR_CONTROL, 32'h8002);
    wr(`SBT_ADDR_COUNT, 32'h0);
    sbt_ext_source_inst.burst(1'b0, 5);
    rd(`SBT_ADDR_COUNT);
    check(q, 32'd5);
    wr(`SBT_ADDR_CONTROL, 32'h8006);
    sbt_ext_source_inst.burst(1'b0, 3);
    rd(`SBT_ADDR_COUNT);
    check(q, 32'd5);
    cpu_sleep <= 1'b0;
    sbt_ext_source_inst.burst(1'b0, 3);
    rd(`SBT_ADDR_COUNT);
    check(q, 32'd8);
  endtask : t_sleep
  task automatic t_osc;
    cpu_sleep <= 1'b1;
    wr(`SBT_ADDR_OSC, 32'h2);
    wr(`SBT_ADDR_CONTROL, 32'h8002);
    wr(`SBT_ADDR_PERIOD, 32'h3);
    wr(`SBT_ADDR_COUNT, 32'h0);
    v = n_wake;
    sbt_ext_source_inst.burst(1'b0, 2);
    rd(`SBT_ADDR_COUNT);
    check(q, 32'h0);
    sbt_ext_source_inst.burst(1'b1, 6);
    rd(`SBT_ADDR_COUNT);
    check(q, 32'd2);
    check(n_wake - v, 32'd1);
  endtask : t_osc

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_prescale();
    t_gate();
    t_idle();
    t_sleep();
    t_osc();
    end_of_test();
  end
endmodule : test_sbt_timer
